// File: logic/down_timer.sv
/*
 Loadable down counter that pulses when it reaches zero.
 Assumes the load value is at least one.
*/
`timescale 1ns/100ps
module down_timer
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   input  wire logic        i_load,
   input  wire logic [27:0] i_count,
   output logic             o_expire,
   output logic             o_busy
);
   logic [27:0] cnt;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         cnt      <= 28'h000_0000;
         o_expire <= 1'b0;
      end
      else if (i_load)
      begin
         cnt      <= i_count;
         o_expire <= 1'b0;
      end
      else
      begin
         o_expire <= (cnt == 28'h000_0001);
         if (cnt != 28'h000_0000)
            cnt <= cnt - 28'h000_0001;
      end
   end

   assign o_busy = (cnt != 28'h000_0000);
endmodule

// File: logic/pin_sync.sv
/*
 Two-flop synchroniser for a group of pin inputs.
 Assumes the pins are asynchronous to the reference clock.
*/
`timescale 1ns/100ps
module pin_sync #(parameter int W = 7, parameter logic [6:0] INIT = 7'h7F)
(
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_pin,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         meta   <= INIT[W-1:0];
         o_sync <= INIT[W-1:0];
      end
      else
      begin
         meta   <= i_pin;
         o_sync <= meta;
      end
   end
endmodule

// File: logic/telemetry_tx_sequencer.sv
/*
 Transmit sequencer for a four-channel telemetry transmitter: watches the
 channel inputs, launches packets, handles acknowledge retries and drives the
 status lamp. Registers sit on a classic Wishbone slave.
 Assumes a radio modem that takes o_pkt on o_tx_start and reports done and
 acknowledge as single-cycle pulses on the reference clock.
*/
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
module telemetry_tx_sequencer
   import tx_seq_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   input  wire logic [3:0]  i_channel_inputs_n,
   input  wire logic        i_ack_request_n,
   input  wire logic        i_auto_allocate_select_n,
   input  wire logic        i_tx_done,
   input  wire logic        i_ack_rx,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [3:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic [31:0]      o_wb_dat,
   output logic             o_wb_ack,
   output logic             o_tx_start,
   output packet_t          o_pkt,
   output logic             o_status_lamp_n,
   output logic             o_sleep
);
   typedef enum logic [4:0] {
      S_IDLE  = 5'b00001,
      S_SEND  = 5'b00010,
      S_AIR   = 5'b00100,
      S_WAIT  = 5'b01000,
      S_FAIL  = 5'b10000
   } state_t;

   state_t      state;
   wb_req_t     req;
   logic [6:0]  pins;
   logic [3:0]  chan;
   logic [3:0]  chan_last;
   logic        ack_mode;
   logic        auto_alloc;
   logic [2:0]  sends;
   logic        change;
   logic        enable;
   logic [33:0] ident;
   logic        ack_seen;
   logic        done_seen;
   logic        fail_seen;
   logic        tmr_load;
   logic [27:0] tmr_count;
   logic        tmr_expire;
   logic        tmr_busy;
   logic        flash_load;
   logic        flash_busy;
   logic [27:0] flick_cnt;
   logic        flick_phase;
   logic [31:0] ctrl_merged;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++)
         if (sel[b])
            r[b*8 +: 8] = new_v[b*8 +: 8];
      return r;
   endfunction

   assign req = '{adr: i_wb_adr, dat: i_wb_dat, we: i_wb_we, sel: i_wb_sel,
                  stb: i_wb_stb, cyc: i_wb_cyc};

   // Only bit 2 of the merged control word is kept
   assign ctrl_merged = merge({29'h0, enable, 2'h0}, req.dat, req.sel);

   // Pins are asynchronous, so all pass two flops first
   pin_sync #(.W(7), .INIT(7'h7F)) u_sync
   (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_pin     ({i_auto_allocate_select_n, i_ack_request_n, i_channel_inputs_n}),
      .o_sync    (pins)
   );

   assign chan       = ~pins[3:0];
   assign ack_mode   = ~pins[4];
   assign auto_alloc = ~pins[5];
   assign change     = (chan != chan_last);

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         chan_last <= 4'h0;
      else if (state == S_IDLE && change && enable)
         chan_last <= chan;
   end

   // Retry spacing and failure window share one timer
   down_timer u_tmr
   (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_load    (tmr_load),
      .i_count   (tmr_count),
      .o_expire  (tmr_expire),
      .o_busy    (tmr_busy)
   );

   // One short lamp flash per send, retries included
   down_timer u_flash
   (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_load    (flash_load),
      .i_count   (28'(FLASH_CYC)),
      .o_expire  (),
      .o_busy    (flash_busy)
   );

   always_comb
   begin
      tmr_load  = 1'b0;
      tmr_count = 28'(RETRY_CYC);
      if (state == S_SEND)
         tmr_load = 1'b1;
      else if (state == S_WAIT && tmr_expire && sends == MAX_SENDS)
      begin
         tmr_load  = 1'b1;
         tmr_count = 28'(FAIL_CYC);
      end
   end

   assign flash_load = (state == S_SEND);

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         state      <= S_IDLE;
         sends      <= 3'h0;
         o_tx_start <= 1'b0;
         o_pkt      <= '0;
      end
      else
      begin
         o_tx_start <= 1'b0;
         case (state)
            S_IDLE:
            begin
               sends <= 3'h0;
               if (change && enable)
               begin
                  o_pkt <= '{ident: ident, chan: chan, ack_req: ack_mode,
                             auto_alloc: auto_alloc};
                  state <= S_SEND;
               end
            end
            S_SEND:
            begin
               o_tx_start <= 1'b1;
               sends      <= sends + 3'h1;
               state      <= S_AIR;
            end
            S_AIR:
            begin
               if (i_ack_rx && o_pkt.ack_req)
                  state <= S_IDLE;
               else if (i_tx_done)
                  state <= o_pkt.ack_req ? S_WAIT : S_IDLE;
            end
            S_WAIT:
            begin
               if (i_ack_rx)
                  state <= S_IDLE;
               else if (tmr_expire)
                  state <= (sends == MAX_SENDS) ? S_FAIL : S_SEND;
            end
            S_FAIL:
            begin
               if (tmr_expire)
                  state <= S_IDLE;
            end
            default:
               state <= S_IDLE;
         endcase
      end
   end

   // Fast flicker for the failure window
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || state != S_FAIL)
      begin
         flick_cnt   <= 28'h000_0000;
         flick_phase <= 1'b0;
      end
      else if (flick_cnt == 28'(FLICKER_CYC - 1))
      begin
         flick_cnt   <= 28'h000_0000;
         flick_phase <= ~flick_phase;
      end
      else
         flick_cnt <= flick_cnt + 28'h000_0001;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         o_status_lamp_n <= 1'b1;
      else if (state == S_FAIL)
         o_status_lamp_n <= ~flick_phase;
      else
         o_status_lamp_n <= ~(flash_busy || flash_load);
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         o_sleep <= 1'b1;
      else
         o_sleep <= (state == S_IDLE) && !change && !flash_busy;
   end

   // Sticky events: a set in the clear cycle wins
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         ack_seen  <= 1'b0;
         done_seen <= 1'b0;
         fail_seen <= 1'b0;
         enable    <= CTRL_RESET[CTRL_ENABLE_BIT];
         ident     <= ID_DEFAULT;
      end
      else
      begin
         if (req.cyc && req.stb && req.we && !o_wb_ack && req.adr == ADR_STATUS
             && req.sel[0])
         begin
            if (i_wb_dat[CTRL_ACK_BIT])
               ack_seen <= 1'b0;
            if (i_wb_dat[CTRL_TXDONE_BIT])
               done_seen <= 1'b0;
            if (i_wb_dat[CTRL_ENABLE_BIT])
               fail_seen <= 1'b0;
         end
         if (i_ack_rx)
            ack_seen <= 1'b1;
         if (i_tx_done)
            done_seen <= 1'b1;
         if (state == S_FAIL)
            fail_seen <= 1'b1;
         if (req.cyc && req.stb && req.we && !o_wb_ack && req.adr == ADR_CTRL)
            enable <= ctrl_merged[CTRL_ENABLE_BIT];
         if (req.cyc && req.stb && req.we && !o_wb_ack && req.adr == ADR_ID)
            ident[31:0] <= merge(ident[31:0], req.dat, req.sel);
      end
   end

   // Wishbone slave: ack one cycle after strobe, dropped the cycle after
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end
      else
      begin
         o_wb_ack <= req.cyc && req.stb && !o_wb_ack;
         case (req.adr)
            ADR_CTRL:   o_wb_dat <= {29'h0, enable, 2'h0};
            ADR_STATUS: o_wb_dat <= {24'h00_0000, state, fail_seen, done_seen, ack_seen};
            ADR_ID:     o_wb_dat <= ident[31:0];
            ADR_PACKET: o_wb_dat <= {22'h0, sends, o_pkt.chan, o_pkt.ack_req,
                                     o_pkt.auto_alloc, 1'b0};
            default:    o_wb_dat <= 32'h0000_0000;
         endcase
      end
   end

   a_idle_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == S_IDLE && !change) |=> !o_tx_start)
      else $error("Start without input change");
   a_change_start: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == S_IDLE && change && enable) |=> ##1 o_tx_start)
      else $error("Input change did not start a packet");
   a_single_shot: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == S_AIR && i_tx_done && !o_pkt.ack_req) |=> state == S_IDLE)
      else $error("Unacknowledged mode repeated");
   a_send_limit: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      sends <= MAX_SENDS)
      else $error("Too many sends");
   a_ack_stop: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == S_WAIT && i_ack_rx) |=> state == S_IDLE ##1 !o_tx_start)
      else $error("Repeat after acknowledge");
   a_fail_entry: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == S_WAIT && tmr_expire && sends == MAX_SENDS && !i_ack_rx) |=> state == S_FAIL)
      else $error("No flicker after five sends");
   a_lamp_dark: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == S_IDLE && !flash_busy && $past(state) == S_IDLE) |=> o_status_lamp_n)
      else $error("Lamp lit while idle");
   a_lamp_flash: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == S_SEND) |=> !o_status_lamp_n)
      else $error("Lamp not low on send");
   a_packet_fields: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == S_IDLE && change && enable) |=> o_pkt.chan == $past(chan)
         && o_pkt.ident == $past(ident) && o_pkt.ack_req == $past(ack_mode))
      else $error("Packet fields wrong");
   a_start_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_tx_start |=> !o_tx_start)
      else $error("Start pulse longer than one cycle");
   a_ack_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_wb_ack |=> !o_wb_ack)
      else $error("Bus acknowledge held");
   a_sleep_busy: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state != S_IDLE) |=> !o_sleep)
      else $error("Sleep flagged while busy");
   a_fail_dwell: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state == S_FAIL && !tmr_expire) |=> state == S_FAIL)
      else $error("Flicker window cut short");
endmodule

// File: logic/tx_seq_pkg.sv
/*
 Package for the telemetry transmit sequencer: register map, field layout,
 reset values, timing counts and the carrier structs.
 Assumes a 200 MHz reference clock.
*/
package tx_seq_pkg;
   localparam int unsigned CLK_HZ          = 200_000_000;
   localparam int unsigned RETRY_MS        = 200;
   localparam int unsigned FAIL_MS         = 1000;
   localparam int unsigned FLASH_MS        = 20;
   localparam int unsigned FLICKER_MS      = 25;
   localparam int unsigned RETRY_CYC       = CLK_HZ / 1000 * RETRY_MS;
   localparam int unsigned FAIL_CYC        = CLK_HZ / 1000 * FAIL_MS;
   localparam int unsigned FLASH_CYC       = CLK_HZ / 1000 * FLASH_MS;
   localparam int unsigned FLICKER_CYC     = CLK_HZ / 1000 * FLICKER_MS;
   localparam logic [2:0]  MAX_SENDS       = 3'h5;

   localparam logic [3:0]  ADR_CTRL        = 4'h0;
   localparam logic [3:0]  ADR_STATUS      = 4'h4;
   localparam logic [3:0]  ADR_ID          = 4'h8;
   localparam logic [3:0]  ADR_PACKET      = 4'hC;

   localparam int          CTRL_ACK_BIT    = 0;
   localparam int          CTRL_TXDONE_BIT = 1;
   localparam int          CTRL_ENABLE_BIT = 2;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0004;
   localparam logic [33:0] ID_DEFAULT      = 34'h0_1234_5678;   // Arbitrary identity

   typedef struct packed {
      logic [33:0] ident;
      logic [3:0]  chan;
      logic        ack_req;
      logic        auto_alloc;
   } packet_t;

   typedef struct packed {
      logic [3:0]  adr;
      logic [31:0] dat;
      logic        we;
      logic [3:0]  sel;
      logic        stb;
      logic        cyc;
   } wb_req_t;
endpackage

// File: tb/modem_model.sv
/*
 Behavioural radio modem and far receiver for the transmit sequencer bench.
 Assumes single-cycle o_tx_start pulses on the reference clock.
*/
`timescale 1ns/100ps
module modem_model
   import tx_seq_pkg::*;
#(parameter int DLY = 8)
(
   input  wire logic    i_ref_clk,
   input  wire logic    i_tx_start,
   input  wire packet_t i_pkt,
   input  wire logic    i_answer,
   output logic         o_tx_done,
   output logic         o_ack_rx,
   output logic [3:0]   o_receiver_outputs,
   output logic [4:0]   o_slots
);
   logic [33:0] peer;
   logic        paired;

   initial
   begin
      o_tx_done          = 1'b0;
      o_ack_rx           = 1'b0;
      o_receiver_outputs = 4'h0;
      o_slots            = 5'h00;
      paired             = 1'b0;
      peer               = '0;
   end

   // Receiver side: auto-allocation learns all four channels into one of thirty slots
   always @(posedge i_ref_clk)
   begin
      if (i_tx_start === 1'b1)
      begin
         if (!paired && i_pkt.auto_alloc && o_slots < 5'h1E)
         begin
            paired  <= 1'b1;
            peer    <= i_pkt.ident;
            o_slots <= o_slots + 5'h01;
         end
         if ((paired && i_pkt.ident == peer) || (!paired && i_pkt.auto_alloc))
            o_receiver_outputs <= i_pkt.chan;
      end
   end

   // Airtime first, then the far receiver replies only when asked to
   always @(posedge i_ref_clk)
   begin
      if (i_tx_start === 1'b1)
      begin
         repeat (DLY) @(posedge i_ref_clk);
         o_tx_done <= 1'b1;
         @(posedge i_ref_clk);
         o_tx_done <= 1'b0;
         if (i_answer && i_pkt.ack_req)
         begin
            repeat (DLY) @(posedge i_ref_clk);
            o_ack_rx <= 1'b1;
            @(posedge i_ref_clk);
            o_ack_rx <= 1'b0;
         end
      end
   end
endmodule

// File: tb/telemetry_tx_sequencer_tb.sv
/*
 Self-checking bench for the telemetry transmit sequencer.
 Assumes the modem model answers on the reference clock; retry spans are too long to run.
*/
`timescale 1ns/100ps
module telemetry_tx_sequencer_tb
   import tx_seq_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  pins = 4'hF;
   logic        ack_n = 1'b1;
   logic        auto_n = 1'b1;
   logic        answer = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic [3:0]  sel = 4'hF;
   logic [3:0]  rx_out;
   logic [4:0]  slots;
   logic [31:0] o_wb_dat;
   logic        o_wb_ack;
   logic        tx_start;
   logic        tx_done;
   logic        ack_rx;
   logic        lamp_n;
   logic        sleep;
   packet_t     pkt;
   int          failures = 0;
   int          checked = 0;
   int          starts = 0;
   int          base;

   initial
   begin
      forever #2.5 clk = ~clk;
   end

   telemetry_tx_sequencer dut_u (
      .i_ref_clk(clk), .i_rst(rst), .i_channel_inputs_n(pins), .i_ack_request_n(ack_n),
      .i_auto_allocate_select_n(auto_n), .i_tx_done(tx_done), .i_ack_rx(ack_rx),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_tx_start(tx_start),
      .o_pkt(pkt), .o_status_lamp_n(lamp_n), .o_sleep(sleep));

   modem_model model_u (
      .i_ref_clk(clk), .i_tx_start(tx_start), .i_pkt(pkt), .i_answer(answer),
      .o_tx_done(tx_done), .o_ack_rx(ack_rx), .o_receiver_outputs(rx_out),
      .o_slots(slots));

   always @(posedge clk)
   begin
      if (tx_start === 1'b1)
         starts++;
   end

   task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (o_wb_ack !== 1'b1 && n < 50);
      rdat = o_wb_dat;
      chk("wb ack", 1'b1, o_wb_ack);
      cyc <= 1'b0; stb <= 1'b0;
   endtask

   task automatic wait_start();
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (tx_start !== 1'b1 && n < 500);
      chk("start", 1'b1, tx_start);
      chk("lamp lit", 1'b0, lamp_n);
   endtask

   task automatic idle_for(input int cyc_n, input int exp_starts);
      repeat (cyc_n) @(posedge clk);
      chk("start count", exp_starts, starts - base);
   endtask

   task automatic t_reset();
      #1;
      chk("sleep", 1'b1, sleep);
      chk("lamp dark", 1'b1, lamp_n);
      wb(1'b0, ADR_CTRL, '0);
      chk("ctrl", CTRL_RESET, rdat);
      wb(1'b0, ADR_ID, '0);
      chk("id", ID_DEFAULT[31:0], rdat);
      wb(1'b0, 4'h2, '0);
      chk("unmapped", '0, rdat);
      base = starts;
      idle_for(200, 0);
   endtask

   task automatic t_noack();
      base = starts;
      @(posedge clk);
      auto_n <= 1'b0; pins <= 4'b1110;
      wait_start();
      chk("packet", {ID_DEFAULT, 4'b0001, 1'b0, 1'b1}, pkt);
      idle_for(300, 1);
      chk("rx outputs", 4'b0001, rx_out);
      chk("slots", 5'h01, slots);
      wb(1'b0, ADR_STATUS, '0);
      chk("state idle", 5'b00001, rdat[7:3]);
      @(posedge clk);
      pins <= 4'b1111;
      wait_start();
      chk("chan released", 4'b0000, pkt.chan);
      idle_for(300, 2);
      chk("rx released", 4'b0000, rx_out);
   endtask

   task automatic t_ack();
      wb(1'b1, ADR_STATUS, 32'h0000_0007);
      wb(1'b0, ADR_STATUS, '0);
      chk("flags cleared", 3'h0, rdat[2:0]);
      base = starts;
      @(posedge clk);
      ack_n <= 1'b0; auto_n <= 1'b1; pins <= 4'b0111;
      wait_start();
      chk("ack flags", {4'b1000, 1'b1, 1'b0}, pkt[5:0]);
      idle_for(1000, 1);
      wb(1'b0, ADR_STATUS, '0);
      chk("ack seen", 1'b1, rdat[0]);
      chk("state idle", 5'b00001, rdat[7:3]);
      chk("rx paired", 4'b1000, rx_out);
      chk("slots kept", 5'h01, slots);
   endtask

   task automatic t_enable();
      wb(1'b1, ADR_CTRL, 32'h0000_0000);
      wb(1'b1, ADR_ID, 32'h0000_ABCD);
      sel <= 4'h1;
      wb(1'b1, ADR_ID, 32'hFFFF_FF12);
      sel <= 4'hF;
      wb(1'b0, ADR_ID, '0);
      chk("id lane", 32'h0000_AB12, rdat);
      base = starts;
      @(posedge clk);
      pins <= 4'b0101;
      idle_for(200, 0);
      wb(1'b1, ADR_CTRL, 32'h0000_0004);
      wait_start();
      chk("new id", {34'h0_0000_AB12, 4'b1010}, pkt[39:2]);
      idle_for(100, 1);
      chk("rx foreign", 4'b1000, rx_out);
   endtask

   task automatic t_noanswer();
      @(posedge clk);
      answer <= 1'b0;
      repeat (300) @(posedge clk);
      base = starts;
      @(posedge clk);
      pins <= 4'b1111;
      wait_start();
      // Full retry span is far too long to simulate, so only early repeats are hunted
      idle_for(3000, 1);
      wb(1'b0, ADR_STATUS, '0);
      chk("state wait", 5'b01000, rdat[7:3]);
      wb(1'b0, ADR_PACKET, '0);
      chk("sends", 3'h1, rdat[9:7]);
      @(posedge clk);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("sleep again", 1'b1, sleep);
      chk("lamp reset", 1'b1, lamp_n);
      wb(1'b0, ADR_STATUS, '0);
      chk("state reset", 5'b00001, rdat[7:3]);
   endtask

   task automatic end_sim();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (60000) @(posedge clk);
      failures++;
      end_sim();
   end

   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_noack();
      t_ack();
      t_enable();
      t_noanswer();
      end_sim();
   end
endmodule
